/* File: shared/bdr_pkg.sv */
package bdr_pkg;
    // Register numbers of the move port
    localparam logic [2:0] REG_AM0  = 3'h0;
    localparam logic [2:0] REG_AM3  = 3'h3;
    localparam logic [2:0] REG_AL4  = 3'h4;
    localparam logic [2:0] REG_AL5  = 3'h5;
    localparam logic [2:0] REG_STAT = 3'h6;
    localparam logic [2:0] REG_CTRL = 3'h7;
    // Status fields and reset value
    localparam int        ST_TASK   = 15;
    localparam int        ST_STEP   = 14;
    localparam int        ST_ACC    = 13;
    localparam logic [63:0] ST_RESET   = 64'h0000_0000_FFFF_0FF0;
    localparam logic [63:0] ST_FIXED1  = 64'h0000_0000_FFFF_0FF0;
    localparam logic [63:0] ST_WMASK   = 64'h0000_0000_0000_E00F;
    // Control fields and reset value
    localparam int        CT_GD     = 13;
    localparam int        CT_TYPE0  = 16;
    localparam int        CT_LEN0   = 18;
    localparam int        CT_STRIDE = 4;
    localparam logic [63:0] CT_RESET   = 64'h0000_0000_0000_0400;
    localparam logic [63:0] CT_FIXED1  = 64'h0000_0000_0000_0400;
    localparam logic [63:0] CT_WMASK   = 64'h0000_0000_FFFF_23FF;
    // Match type codes
    localparam logic [1:0] TY_EXEC  = 2'h0;
    localparam logic [1:0] TY_WR    = 2'h1;
    localparam logic [1:0] TY_IO    = 2'h2;
    localparam logic [1:0] TY_RW    = 2'h3;
    // Length codes
    localparam logic [1:0] LN_1     = 2'h0;
    localparam logic [1:0] LN_2     = 2'h1;
    localparam logic [1:0] LN_8     = 2'h2;
    localparam logic [1:0] LN_4     = 2'h3;
    // Reference kinds from the pipeline
    localparam logic [1:0] RK_EXEC  = 2'h0;
    localparam logic [1:0] RK_RD    = 2'h1;
    localparam logic [1:0] RK_WR    = 2'h2;
    localparam logic [1:0] RK_IO    = 2'h3;
    // Outcome of a move request
    typedef enum logic [1:0] {
        BDR_MV_OK = 2'b00,
        BDR_MV_GP = 2'b01,
        BDR_MV_UD = 2'b10,
        BDR_MV_DB = 2'b11
    } bdr_mv_e;
endpackage

/* File: hw/bdr_match.sv */
`timescale 1ns/1ps
// One address comparator with length mask and type qualifier
module bdr_match
    import bdr_pkg::*;
#(
    parameter int AW = 64
) (
    // Programmed condition
    input  wire logic [AW-1:0] bp_addr,
    input  wire logic [1:0]    bp_type,
    input  wire logic [1:0]    bp_len,
    input  wire logic          bp_en,
    input  wire logic          debug_extensions_on,
    input  wire logic          long_mode,
    // Reference
    input  wire logic [AW-1:0] ref_addr,
    input  wire logic [1:0]    ref_kind,
    // Result
    output logic               hit
);
    logic [AW-1:0] mask;
    logic          type_ok;

    // Low address bits masked by length; 8 bytes only in long mode
    always_comb begin
        mask = '1;
        unique case (bp_len)
            LN_1: mask = '1;
            LN_2: mask = {{(AW-1){1'b1}}, 1'b0};
            LN_4: mask = {{(AW-2){1'b1}}, 2'b00};
            LN_8: mask = long_mode ? {{(AW-3){1'b1}}, 3'b000} : '1; // see R19
        endcase
    end

    // Code 10 matches I/O only with extensions on, else never
    always_comb begin
        type_ok = 1'b0;
        unique case (bp_type)
            TY_EXEC: type_ok = (ref_kind == RK_EXEC);
            TY_WR:   type_ok = (ref_kind == RK_WR);
            TY_IO:   type_ok = debug_extensions_on && (ref_kind == RK_IO); // see R18
            TY_RW:   type_ok = (ref_kind == RK_RD) || (ref_kind == RK_WR);
        endcase
    end

    assign hit = bp_en && type_ok && ((ref_addr & mask) == (bp_addr & mask)); // see R22
endmodule

/* File: hw/bdr_unit.sv */
`timescale 1ns/1ps
// Summary of operation
// R1 - Registers 64 bit; legacy zero-extends, reads low
// R2 - 64-bit mode moves full width always
// R3 - Moves only at privilege zero, else fault
// R4 - Breakpoint addresses stored without canonical check
// R5 - Numbers four, five alias status, control
// R6 - Four or five faults invalid-opcode with extensions
// R7 - Status loaded on each debug exception
// R8 - Bits 15:13 never cleared by hardware
// R9 - Bits 3:0 rewritten on every breakpoint event
// R10 - Bit 13 set on move while detect
// R11 - Bit 14 set on single step, highest
// R12 - Bit 15 set on trapped task switch
// R13 - Reserved status bits fixed ones and zero
// R14 - 64-bit upper status ones fault protection
// R15 - Control holds enables, conditions, detect enable
// R16 - Length fields at 19:18 through 31:30
// R17 - Type fields at 17:16 through 29:28
// R18 - Type code selects execute, write, I/O, access
// R19 - Length code masks low address bits
// R20 - Task switch clears local enables only
// R21 - Detect enable faults moves; cleared on entry
// R22 - Hit needs masked equal, type, enable
module bdr_unit
    import bdr_pkg::*;
#(
    parameter int NBP = 4,
    parameter int AW  = 64
) (
    // Clock and reset
    input  wire logic               clk_sys,
    input  wire logic               rst_n,
    // Execution mode
    input  wire logic               mode_64,
    input  wire logic               long_mode,
    input  wire logic               debug_extensions_on,
    input  wire logic [1:0]         current_privilege_level,
    // Debug register move request
    input  wire logic               mv_valid,
    input  wire logic               mv_write,
    input  wire logic [2:0]         mv_reg,
    input  wire logic [63:0]        mv_wdata,
    // Move answer
    output logic                    mv_done,
    output bdr_pkg::bdr_mv_e        mv_result,
    output logic [63:0]             mv_rdata,
    // Reference from the pipeline
    input  wire logic               ref_valid,
    input  wire logic [AW-1:0]      ref_addr,
    input  wire logic [1:0]         ref_kind,
    // Other debug events
    input  wire logic               trap_flag_single_step,
    input  wire logic               task_switch,
    input  wire logic               task_trap_bit,
    input  wire logic               handler_entry,
    // Exception out
    output logic                    debug_exception,
    // State visible to the core
    output logic [63:0]             debug_cause_status,
    output logic [63:0]             breakpoint_control
);
    logic [63:0]    address_match_regs [NBP];
    logic [63:0]    stat_r;
    logic [63:0]    ctrl_r;
    logic [NBP-1:0] bp_hit;
    logic [NBP-1:0] breakpoint_hit_flags;
    logic           general_detect_enable;
    logic           access_ok;
    logic           alias_bad;
    logic           gp_upper;
    logic           detect_trap;
    logic           do_write;
    logic           bp_event;
    logic           step_event;
    logic           task_event;
    logic           any_event;
    logic [2:0]     eff_reg;
    logic [63:0]    wval;
    logic [63:0]    rval;
    logic           done_r;
    bdr_mv_e        result_r;
    logic [63:0]    rdata_r;
    logic           dbx_r;

    assign general_detect_enable = ctrl_r[CT_GD];

    // One comparator per breakpoint, fields at fixed strides
    for (genvar i = 0; i < NBP; i++) begin : g_bp
        logic en;
        assign en = ctrl_r[2*i] | ctrl_r[2*i+1];
        bdr_match #(.AW(AW)) u_match (
            .bp_addr             (address_match_regs[i][AW-1:0]),
            .bp_type             (ctrl_r[CT_TYPE0 + CT_STRIDE*i +: 2]), // see R17
            .bp_len              (ctrl_r[CT_LEN0 + CT_STRIDE*i +: 2]),  // see R16
            .bp_en               (en),                                  // see R15
            .debug_extensions_on (debug_extensions_on),
            .long_mode           (long_mode),
            .ref_addr            (ref_addr),
            .ref_kind            (ref_kind),
            .hit                 (bp_hit[i])
        );
    end
    assign breakpoint_hit_flags = ref_valid ? bp_hit : '0;

    // Move checks; privilege first, then opcode, then detect, then value
    assign access_ok   = (current_privilege_level == 2'h0); // see R3
    assign alias_bad   = debug_extensions_on &&
                         (mv_reg == REG_AL4 || mv_reg == REG_AL5); // see R6
    assign eff_reg     = (mv_reg == REG_AL4) ? REG_STAT :
                         (mv_reg == REG_AL5) ? REG_CTRL : mv_reg; // see R5
    assign detect_trap = general_detect_enable; // see R21
    assign gp_upper    = mode_64 && mv_write && (eff_reg == REG_STAT) &&
                         (mv_wdata[63:32] != 32'h0); // see R14
    assign do_write    = mv_valid && mv_write && access_ok && !alias_bad &&
                         !detect_trap && !gp_upper;
    // Legacy writes zero-extend the low half
    assign wval        = mode_64 ? mv_wdata : {32'h0, mv_wdata[31:0]}; // see R1 R2

    // Events that raise the debug exception
    assign bp_event   = |breakpoint_hit_flags;
    assign step_event = trap_flag_single_step;
    assign task_event = task_switch && task_trap_bit;
    assign any_event  = bp_event || step_event || task_event ||
                        (mv_valid && access_ok && !alias_bad && detect_trap);

    // Read mux over the effective register
    always_comb begin
        rval = 64'h0;
        if (eff_reg <= REG_AM3) begin
            rval = address_match_regs[eff_reg[1:0]];
        end else if (eff_reg == REG_STAT) begin
            rval = stat_r;
        end else begin
            rval = ctrl_r;
        end
    end

    // Address registers take the value as written, no canonical test
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int i = 0; i < NBP; i++) begin
                address_match_regs[i] <= 64'h0;
            end
        end else if (do_write && eff_reg <= REG_AM3) begin
            address_match_regs[eff_reg[1:0]] <= wval; // see R4
        end
    end

    // Status: software write applied first, hardware causes then set over it in the same cycle
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stat_r <= ST_RESET;
        end else begin
            logic [63:0] s;
            s = stat_r;
            if (do_write && eff_reg == REG_STAT) begin
                s = (wval & ST_WMASK) | ST_FIXED1; // see R13
            end
            if (any_event) begin // see R7
                if (bp_event || (mv_valid && access_ok && !alias_bad && detect_trap)) begin
                    s[NBP-1:0] = breakpoint_hit_flags; // see R9
                end
                if (mv_valid && access_ok && !alias_bad && detect_trap) begin
                    s[ST_ACC] = 1'b1; // see R10
                end
                if (step_event) begin
                    s[ST_STEP] = 1'b1; // see R11
                end
                if (task_event) begin
                    s[ST_TASK] = 1'b1; // see R12
                end
            end
            // Bits 15:13 only ever set here; clearing is software's job
            stat_r <= s; // see R8
        end
    end

    // Control: local enables drop on task switch, detect drops on handler entry
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            ctrl_r <= CT_RESET;
        end else begin
            logic [63:0] c;
            c = ctrl_r;
            if (do_write && eff_reg == REG_CTRL) begin
                c = (wval & CT_WMASK) | CT_FIXED1;
            end
            if (task_switch) begin
                for (int i = 0; i < NBP; i++) begin
                    c[2*i] = 1'b0; // see R20
                end
            end
            if (handler_entry) begin
                c[CT_GD] = 1'b0; // see R21
            end
            ctrl_r <= c;
        end
    end

    // Move answer, one cycle after the request
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            done_r   <= 1'b0;
            result_r <= BDR_MV_OK;
            rdata_r  <= 64'h0;
        end else begin
            done_r <= mv_valid;
            if (mv_valid) begin
                if (!access_ok) begin
                    result_r <= BDR_MV_GP; // see R3
                end else if (alias_bad) begin
                    result_r <= BDR_MV_UD; // see R6
                end else if (detect_trap) begin
                    result_r <= BDR_MV_DB; // see R21
                end else if (gp_upper) begin
                    result_r <= BDR_MV_GP; // see R14
                end else begin
                    result_r <= BDR_MV_OK;
                end
                if (!mv_write && access_ok && !alias_bad && !detect_trap) begin
                    rdata_r <= mode_64 ? rval : {32'h0, rval[31:0]}; // see R1 R2
                end else begin
                    rdata_r <= 64'h0;
                end
            end
        end
    end

    // Exception pulse registered with the status update
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dbx_r <= 1'b0;
        end else begin
            dbx_r <= any_event;
        end
    end

    assign mv_done            = done_r;
    assign mv_result          = result_r;
    assign mv_rdata           = rdata_r;
    assign debug_exception    = dbx_r;
    assign debug_cause_status = stat_r;
    assign breakpoint_control = ctrl_r;
endmodule

/* File: sim/bdr_unit_asserts.sv */
`timescale 1ns/1ps
// Watches the move port, events and the two visible registers
module bdr_unit_asserts
    import bdr_pkg::*;
(
    // Clock, reset and mode
    input wire logic             clk_sys,
    input wire logic             rst_n,
    input wire logic             mode_64,
    input wire logic             debug_extensions_on,
    input wire logic [1:0]       current_privilege_level,
    // Move port
    input wire logic             mv_valid,
    input wire logic             mv_write,
    input wire logic [2:0]       mv_reg,
    input wire bdr_pkg::bdr_mv_e mv_result,
    input wire logic [63:0]      mv_rdata,
    // Events and state
    input wire logic             trap_flag_single_step,
    input wire logic             task_switch,
    input wire logic             task_trap_bit,
    input wire logic             debug_exception,
    input wire logic [63:0]      debug_cause_status,
    input wire logic [63:0]      breakpoint_control
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // A move that passes privilege and alias checks
    wire ok_mv = mv_valid && current_privilege_level == 2'h0 &&
                 !(debug_extensions_on && mv_reg[2:1] == 2'h2);
    wire [2:0] sticky = debug_cause_status[15:13];

    a_priv_fault: assert property (mv_valid && current_privilege_level != 2'h0
        |=> mv_result == BDR_MV_GP) else $error("move above level zero not refused");
    a_alias_fault: assert property (mv_valid && current_privilege_level == 2'h0 &&
        debug_extensions_on && mv_reg[2:1] == 2'h2 |=> mv_result == BDR_MV_UD)
        else $error("alias move with extensions not refused");
    a_detect_fault: assert property (ok_mv && breakpoint_control[CT_GD]
        |=> mv_result == BDR_MV_DB && debug_cause_status[ST_ACC] && debug_exception)
        else $error("move under general detect not trapped");
    a_reserved_status: assert property ((debug_cause_status & ~ST_WMASK) == ST_FIXED1)
        else $error("reserved status bits wrong");
    a_sticky_bits: assert property (|($past(sticky) & ~sticky)
        |-> $past(mv_valid) && $past(mv_write)) else $error("status 15:13 cleared by hardware");
    a_step_bit: assert property (trap_flag_single_step
        |=> debug_cause_status[ST_STEP] && debug_exception) else $error("single step lost");
    a_task_bit: assert property (task_switch && task_trap_bit
        |=> debug_cause_status[ST_TASK] && debug_exception) else $error("task trap lost");
    a_local_clear: assert property (task_switch && !mv_valid |=>
        (breakpoint_control & 64'h55) == 64'h0 &&
        (breakpoint_control & 64'hAA) == ($past(breakpoint_control) & 64'hAA))
        else $error("task switch enables wrong");
    a_legacy_read: assert property (mv_valid && !mv_write && !mode_64
        |=> mv_rdata[63:32] == 32'h0) else $error("legacy read upper half not zero");
endmodule

bind bdr_unit bdr_unit_asserts u_bdr_unit_asserts (.clk_sys, .rst_n, .mode_64,
    .debug_extensions_on, .current_privilege_level, .mv_valid, .mv_write, .mv_reg,
    .mv_result, .mv_rdata, .trap_flag_single_step, .task_switch, .task_trap_bit,
    .debug_exception, .debug_cause_status, .breakpoint_control);

/* File: sim/bdr_pipe_model.sv */
`timescale 1ns/1ps
// Pipeline stand-in: one reference per call, then the bus shows junk
module bdr_pipe_model (
    // Clock
    input wire logic    clk_sys,
    // Reference out
    output logic        ref_valid,
    output logic [63:0] ref_addr,
    output logic [1:0]  ref_kind
);
    // Idle state at time zero
    initial begin
        ref_valid = 1'h0;
        ref_addr = 64'h0;
        ref_kind = 2'h0;
    end
    // Inverting on release keeps a stale address from passing as a live one
    task automatic issue(input logic [63:0] a, input logic [1:0] k);
        @(negedge clk_sys);
        ref_valid = 1'h1;
        ref_addr = a;
        ref_kind = k;
        @(negedge clk_sys);
        ref_valid = 1'h0;
        ref_addr = ~a;
        ref_kind = ~k;
    endtask
endmodule

/* File: sim/bdr_unit_tb_top.sv */
`timescale 1ns/1ps
// Move sequences against the debug register unit
module bdr_unit_tb_top;
    import bdr_pkg::*;
    logic clk_sys, rst_n, mode_64, long_mode, debug_extensions_on, mv_valid, mv_write;
    logic trap_flag_single_step, task_switch, task_trap_bit, handler_entry;
    logic ref_valid, mv_done, debug_exception;
    logic [1:0] current_privilege_level, ref_kind;
    logic [2:0] mv_reg;
    logic [63:0] mv_wdata, ref_addr, mv_rdata, debug_cause_status, breakpoint_control;
    bdr_mv_e mv_result;
    int err_count, cmp_count;
    logic [1:0] kinds [4] = '{RK_EXEC, RK_WR, RK_IO, RK_RD};

    bdr_unit u_bdr_unit (.clk_sys, .rst_n, .mode_64, .long_mode, .debug_extensions_on,
        .current_privilege_level, .mv_valid, .mv_write, .mv_reg, .mv_wdata, .mv_done,
        .mv_result, .mv_rdata, .ref_valid, .ref_addr, .ref_kind, .trap_flag_single_step,
        .task_switch, .task_trap_bit, .handler_entry, .debug_exception,
        .debug_cause_status, .breakpoint_control);
    bdr_pipe_model u_bdr_pipe_model (.clk_sys, .ref_valid, .ref_addr, .ref_kind);

    // 200 MHz clock
    initial begin
        clk_sys = 1'h0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask

    // One move; the answer is due exactly one cycle after it is taken
    task automatic mv(input logic w, input logic [2:0] r, input logic [63:0] d,
                      input bdr_mv_e res);
        @(negedge clk_sys);
        {mv_valid, mv_write, mv_reg, mv_wdata} = {1'h1, w, r, d};
        @(negedge clk_sys);
        mv_valid = 1'h0;
        chk("mv_done", 64'h1, mv_done);
        chk("mv_result", res, mv_result);
    endtask

    task automatic pulse(input logic [2:0] e, input logic x);
        @(negedge clk_sys);
        {trap_flag_single_step, task_switch, handler_entry} = e;
        @(negedge clk_sys);
        {trap_flag_single_step, task_switch, handler_entry} = 3'h0;
        chk("debug_exception", x, debug_exception);
    endtask

    task automatic give_verdict;
        $display("Counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Watchdog against a hang
    initial begin
        #100us;
        err_count++;
        give_verdict();
    end

    // Main sequence
    initial begin
        // Extensions start off so the alias write below is legal; no move pending in reset
        {rst_n, mode_64, long_mode, debug_extensions_on, mv_valid, mv_write} = 6'h18;
        {trap_flag_single_step, task_switch, task_trap_bit, handler_entry} = 4'h0;
        current_privilege_level = 2'h0;
        mv_reg = 3'h0;
        mv_wdata = 64'h0;
        err_count = 0;
        cmp_count = 0;
        repeat (3) @(negedge clk_sys);
        rst_n = 1'h1;
        chk("status", 64'hFFFF0FF0, debug_cause_status);
        chk("control", 64'h400, breakpoint_control);
        $display("test reset done");
        mv(1'h1, REG_AM0, 64'h8000_1234_0000_1000, BDR_MV_OK);
        mv(1'h0, REG_AM0, 64'h0, BDR_MV_OK);
        chk("am0", 64'h8000_1234_0000_1000, mv_rdata);
        mode_64 = 1'h0;
        mv(1'h0, REG_AM0, 64'h0, BDR_MV_OK);
        chk("am0_low", 64'h1000, mv_rdata);
        mv(1'h1, REG_AM3, 64'hFFFF_FFFF_0000_2000, BDR_MV_OK);
        mode_64 = 1'h1;
        mv(1'h0, REG_AM3, 64'h0, BDR_MV_OK);
        chk("am3", 64'h2000, mv_rdata);
        current_privilege_level = 2'h3;
        mv(1'h0, REG_AM0, 64'h0, BDR_MV_GP);
        chk("gp_rdata", 64'h0, mv_rdata);
        current_privilege_level = 2'h0;
        // Breakpoint zero gets a plain address for the matching tests
        mv(1'h1, REG_AM0, 64'h1000, BDR_MV_OK);
        $display("test width and privilege done");
        mv(1'h1, REG_AL5, 64'hD0001, BDR_MV_OK);
        mv(1'h0, REG_CTRL, 64'h0, BDR_MV_OK);
        chk("control", 64'hD0401, mv_rdata);
        debug_extensions_on = 1'h1;
        mv(1'h0, REG_AL4, 64'h0, BDR_MV_UD);
        mv(1'h1, REG_STAT, 64'h1_FFFF_0FF0, BDR_MV_GP);
        chk("status", 64'hFFFF0FF0, debug_cause_status);
        u_bdr_pipe_model.issue(64'h1003, RK_WR);
        chk("hit", 64'h1, debug_exception);
        chk("hits", 64'h1, debug_cause_status[3:0]);
        u_bdr_pipe_model.issue(64'h1004, RK_WR);
        chk("len_miss", 64'h0, debug_exception);
        u_bdr_pipe_model.issue(64'h1000, RK_RD);
        chk("type_miss", 64'h0, debug_exception);
        for (int t = 0; t < 4; t++) begin
            mv(1'h1, REG_CTRL, (64'(t) << 16) | 64'h2, BDR_MV_OK);
            u_bdr_pipe_model.issue(64'h1000, kinds[t]);
            chk("type_hit", 64'h1, debug_exception);
        end
        // Eight-byte length only widens the match in long mode
        mv(1'h1, REG_CTRL, 64'h90002, BDR_MV_OK);
        u_bdr_pipe_model.issue(64'h1007, RK_WR);
        chk("len8_hit", 64'h1, debug_exception);
        long_mode = 1'h0;
        u_bdr_pipe_model.issue(64'h1007, RK_WR);
        chk("len8_legacy", 64'h0, debug_exception);
        debug_extensions_on = 1'h0;
        mv(1'h1, REG_CTRL, 64'h20002, BDR_MV_OK);
        u_bdr_pipe_model.issue(64'h1000, RK_IO);
        chk("io_off", 64'h0, debug_exception);
        $display("test matching done");
        mv(1'h1, REG_CTRL, 64'hFF, BDR_MV_OK);
        task_trap_bit = 1'h1;
        pulse(3'h4, 1'h1);
        chk("step", 64'h1, debug_cause_status[ST_STEP]);
        pulse(3'h2, 1'h1);
        chk("task", 64'h1, debug_cause_status[ST_TASK]);
        chk("control", 64'h4AA, breakpoint_control);
        u_bdr_pipe_model.issue(64'h1000, RK_EXEC);
        chk("sticky", 64'h3, debug_cause_status[15:14]);
        chk("hits", 64'h1, debug_cause_status[3:0]);
        mv(1'h1, REG_STAT, 64'hFFFF0FF0, BDR_MV_OK);
        chk("cleared", 64'hFFFF0FF0, debug_cause_status);
        $display("test events done");
        mv(1'h1, REG_CTRL, 64'h2000, BDR_MV_OK);
        mv(1'h0, REG_AM0, 64'h0, BDR_MV_DB);
        chk("access_hit", 64'h1, debug_cause_status[ST_ACC]);
        chk("db", 64'h1, debug_exception);
        pulse(3'h1, 1'h0);
        chk("gd_clear", 64'h0, breakpoint_control[CT_GD]);
        mv(1'h0, REG_AM0, 64'h0, BDR_MV_OK);
        $display("test general detect done");
        give_verdict();
    end
endmodule
